// ---- pkg/uart_status_pkg.sv ----
// Shared constants for the UART line and modem status block.
package uart_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the host register port
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_RX_DATA   = 3'h0;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_RESUME2   = 3'h5;
  localparam logic [2:0] OFS_MODEM     = 3'h6;

  // ----------------------------------------------------------------
  // Access keys and select bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0] ENH_ACCESS_KEY = 8'hbf;
  localparam int         LFC_DIVSEL_BIT = 7;
  localparam int         MOC_REGSEL_BIT = 2;
  localparam int         MOC_OUT2_BIT   = 3;
  localparam int         MOC_LOOP_BIT   = 4;
  localparam int         SFS_SEL_BIT    = 2;

  // ----------------------------------------------------------------
  // Line status field positions and reset values
  // ----------------------------------------------------------------
  localparam int LSF_FIFO_ERR = 7;
  localparam int LSF_TEMT     = 6;
  localparam int LSF_THRE     = 5;
  localparam int LSF_BREAK    = 4;
  localparam int LSF_FRAME    = 3;
  localparam int LSF_PARITY   = 2;
  localparam int LSF_OVERRUN  = 1;
  localparam int LSF_READY    = 0;
  localparam int MLF_CD       = 7;
  localparam logic [7:0] LINE_STAT_RESET = 8'h60;
  localparam logic [7:0] RESUME2_RESET   = 8'h00;
  localparam logic [7:0] MODEM_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Receive FIFO geometry: data plus break, framing, parity flags
  // ----------------------------------------------------------------
  localparam int RXF_DEPTH = 64;
  localparam int RXF_AW    = 6;
  localparam int RXF_WIDTH = 11;
  localparam int RXF_BRK   = 10;
  localparam int RXF_FRM   = 9;
  localparam int RXF_PAR   = 8;

endpackage

// ---- pkg/rx_fifo_if.sv ----
// Carrier between the status block and its receive error FIFO.
`timescale 1ns/1ps
interface rx_fifo_if;
  import uart_status_pkg::*;
  logic                 push;
  logic                 pop;
  logic                 clear;
  logic [RXF_WIDTH-1:0] wdata;
  logic [RXF_WIDTH-1:0] rdata;
  logic                 full;
  logic                 empty;
  logic                 any_err;
  modport user  (output push, pop, clear, wdata, input rdata, full, empty, any_err);
  modport store (input push, pop, clear, wdata, output rdata, full, empty, any_err);
endinterface

// ---- logic/rx_err_fifo.sv ----
// Receive FIFO holding each byte with its break, framing and parity flags.
`timescale 1ns/1ps
module rx_err_fifo
  import uart_status_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // FIFO port.
  rx_fifo_if.store  fifo
);

  logic [RXF_WIDTH-1:0] mem_reg [RXF_DEPTH];
  logic [RXF_AW-1:0]    wr_ptr_reg;
  logic [RXF_AW-1:0]    rd_ptr_reg;
  logic [RXF_AW:0]      count_reg;
  logic [RXF_AW:0]      err_cnt_reg;
  logic                 do_push;
  logic                 do_pop;

  // True when a stored entry carries any receive error.
  function automatic logic has_err(input logic [RXF_WIDTH-1:0] e);
    return e[RXF_BRK] | e[RXF_FRM] | e[RXF_PAR];
  endfunction

  // A push into a full FIFO is dropped here; the caller flags the overrun.
  assign do_push       = fifo.push && (count_reg != 7'(RXF_DEPTH));
  assign do_pop        = fifo.pop && (count_reg != '0);
  assign fifo.full     = (count_reg == 7'(RXF_DEPTH));
  assign fifo.empty    = (count_reg == '0);
  assign fifo.rdata    = mem_reg[rd_ptr_reg];
  assign fifo.any_err  = (err_cnt_reg != '0);

  // Storage keeps the error flags beside each byte.
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= fifo.wdata;
    end
  end

  // Pointers, occupancy and the count of erroneous entries.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || fifo.clear) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      err_cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
      count_reg   <= count_reg + 7'(do_push) - 7'(do_pop);
      err_cnt_reg <= err_cnt_reg + 7'(do_push && has_err(fifo.wdata))
                     - 7'(do_pop && has_err(mem_reg[rd_ptr_reg]));
    end
  end

endmodule

// ---- logic/uart_line_modem_status.sv ----
// Line status, second resume character and carrier detect status of the UART.
`timescale 1ns/1ps

// What this block does
// - FIFO error summary is high while any stored byte has an error.
// - Transmitter-empty sets on idle, clears while holding or shift register is loaded.
// - Holding-empty sets when the last byte moves to the shift register.
// - Break flag describes the byte at the receive FIFO head.
// - Framing error flag describes the byte at the receive FIFO head.
// - Parity error flag describes the byte at the receive FIFO head.
// - Byte arriving at a full FIFO sets overrun and is dropped.
// - Data ready is high while the receive FIFO holds any byte.
// - Second resume character reachable only under enhanced key and select bit zero.
// - Second resume character resets at power-on only, survives software reset.
// - Modem status readable only with all three select bits zero.
// - Carrier detect status is the inverse of the pin outside loopback.
// - In loopback carrier detect status follows the second output control bit.
// - Line status readable with divisor select zero, resets to both empty flags.
// - Loopback routes transmit output to the receive input.
module uart_line_modem_status
  import uart_status_pkg::*;
(
  // Clock, power-on reset and software reset.
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sw_reset_i,
  // Host register port.
  input  wire logic [2:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Control register values held elsewhere in the UART.
  input  wire logic [7:0] line_format_control_i,
  input  wire logic [7:0] modem_output_control_i,
  input  wire logic [7:0] special_function_select_i,
  // Receiver character strobe with its error flags.
  input  wire logic       rx_push_i,
  input  wire logic [7:0] rx_char_i,
  input  wire logic       rx_break_i,
  input  wire logic       rx_frame_err_i,
  input  wire logic       rx_parity_err_i,
  // Transmitter status.
  input  wire logic       tx_hold_load_i,
  input  wire logic       tx_to_shift_i,
  input  wire logic       tx_hold_last_i,
  input  wire logic       tx_shift_busy_i,
  // Serial lines and modem pin.
  input  wire logic       tx_serial_i,
  input  wire logic       rx_pin_i,
  output logic            rx_serial_o,
  input  wire logic       carrier_detect_n_i,
  output logic [7:0]      second_resume_char_o
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  rx_fifo_if fifo ();

  logic       overrun_reg;
  logic       overrun_next;
  logic       thre_reg;
  logic       thre_next;
  logic       temt_reg;
  logic       temt_next;
  logic [7:0] line_state_flags;
  logic [7:0] modem_line_flags;
  logic       loopback;
  logic       line_sel;
  logic       modem_sel;
  logic       resume2_sel;
  logic       rhr_sel;
  logic       line_read;

  // Register windows depend on the select bits the host has set beforehand.
  assign loopback    = modem_output_control_i[MOC_LOOP_BIT];
  assign resume2_sel = (reg_addr_i == OFS_RESUME2)
                       && (line_format_control_i == ENH_ACCESS_KEY)
                       && !special_function_select_i[SFS_SEL_BIT];
  assign line_sel    = (reg_addr_i == OFS_LINE_STAT)
                       && !line_format_control_i[LFC_DIVSEL_BIT];
  assign modem_sel   = (reg_addr_i == OFS_MODEM)
                       && !line_format_control_i[LFC_DIVSEL_BIT]
                       && !modem_output_control_i[MOC_REGSEL_BIT]
                       && !special_function_select_i[SFS_SEL_BIT];
  assign rhr_sel     = (reg_addr_i == OFS_RX_DATA) && !line_format_control_i[LFC_DIVSEL_BIT];
  assign line_read   = reg_rd_i && line_sel;

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  assign fifo.push  = rx_push_i;
  assign fifo.pop   = reg_rd_i && rhr_sel;
  assign fifo.clear = sw_reset_i;
  assign fifo.wdata = {rx_break_i, rx_frame_err_i, rx_parity_err_i, rx_char_i};

  rx_err_fifo rx_err_fifo_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .fifo      (fifo.store)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Overrun is sticky until the host reads line status; a new overrun in
  // the read cycle wins so it is never lost. The dropped byte is refused
  // by the FIFO itself.
  always_comb begin
    overrun_next = overrun_reg;
    if (line_read) begin
      overrun_next = 1'b0;
    end
    if (rx_push_i && fifo.full) begin
      overrun_next = 1'b1;
    end
  end

  // Holding-empty clears on a host load and sets when the final byte leaves;
  // the set wins if both land together.
  always_comb begin
    thre_next = thre_reg;
    if (tx_hold_load_i) begin
      thre_next = 1'b0;
    end
    if (tx_to_shift_i && tx_hold_last_i) begin
      thre_next = 1'b1;
    end
    temt_next = thre_next && !tx_shift_busy_i;
  end

  // Flags follow software reset too, but with their power-on values.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sw_reset_i) begin
      overrun_reg <= LINE_STAT_RESET[LSF_OVERRUN];
      thre_reg    <= LINE_STAT_RESET[LSF_THRE];
      temt_reg    <= LINE_STAT_RESET[LSF_TEMT];
    end else begin
      overrun_reg <= overrun_next;
      thre_reg    <= thre_next;
      temt_reg    <= temt_next;
    end
  end

  // Head flags come from the stored entry, so they track each pop.
  always_comb begin
    line_state_flags               = 8'h00;
    line_state_flags[LSF_FIFO_ERR] = fifo.any_err;
    line_state_flags[LSF_TEMT]     = temt_reg;
    line_state_flags[LSF_THRE]     = thre_reg;
    line_state_flags[LSF_BREAK]    = !fifo.empty && fifo.rdata[RXF_BRK];
    line_state_flags[LSF_FRAME]    = !fifo.empty && fifo.rdata[RXF_FRM];
    line_state_flags[LSF_PARITY]   = !fifo.empty && fifo.rdata[RXF_PAR];
    line_state_flags[LSF_OVERRUN]  = overrun_reg;
    line_state_flags[LSF_READY]    = !fifo.empty;
  end

  // Only carrier detect lives here; the other modem bits read as zero.
  always_comb begin
    modem_line_flags         = MODEM_RESET;
    modem_line_flags[MLF_CD] = loopback ? modem_output_control_i[MOC_OUT2_BIT]
                                        : !carrier_detect_n_i;
  end

  // ----------------------------------------------------------------
  // Second resume character and read port
  // ----------------------------------------------------------------
  // Power-on reset only: software reset must not wipe flow control setup.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      second_resume_char_o <= RESUME2_RESET;
    end else if (reg_wr_i && resume2_sel) begin
      second_resume_char_o <= reg_wdata_i;
    end
  end

  // Read data is registered; writes to status offsets fall through unused.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (resume2_sel) begin
        reg_rdata_o <= second_resume_char_o;
      end else if (line_sel) begin
        reg_rdata_o <= line_state_flags;
      end else if (modem_sel) begin
        reg_rdata_o <= modem_line_flags;
      end else if (rhr_sel) begin
        reg_rdata_o <= fifo.rdata[7:0];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // Loopback isolates the receive input from the pin.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_serial_o <= 1'b1;
    end else begin
      rx_serial_o <= loopback ? tx_serial_i : rx_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_fifo_err;
    fifo.empty |-> !fifo.any_err;
  endproperty
  a_fifo_err: assert property (p_fifo_err) else $error("error summary with empty fifo");

  property p_temt;
    !sw_reset_i && (tx_hold_load_i || tx_shift_busy_i) && !tx_to_shift_i |=> !temt_reg;
  endproperty
  a_temt: assert property (p_temt) else $error("transmitter empty while loaded");

  property p_thre;
    !sw_reset_i && tx_to_shift_i && tx_hold_last_i |=> thre_reg;
  endproperty
  a_thre: assert property (p_thre) else $error("holding empty not set");

  property p_break;
    reg_rd_i && line_sel && !fifo.empty && fifo.rdata[RXF_BRK] |=> reg_rdata_o[LSF_BREAK];
  endproperty
  a_break: assert property (p_break) else $error("break flag missing");

  property p_overrun;
    // A pop in the same cycle frees one slot, but the late byte stays lost.
    !sw_reset_i && rx_push_i && fifo.full |=> overrun_reg && (fifo.full != $past(fifo.pop));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_ready;
    !sw_reset_i && rx_push_i && !fifo.pop |=> line_state_flags[LSF_READY];
  endproperty
  a_ready: assert property (p_ready) else $error("data ready missing");

  property p_resume_keep;
    !(reg_wr_i && resume2_sel) |=> $stable(second_resume_char_o);
  endproperty
  a_resume_keep: assert property (p_resume_keep) else $error("resume char changed");

  property p_cd_pin;
    reg_rd_i && modem_sel && !loopback |=> reg_rdata_o[MLF_CD] == !$past(carrier_detect_n_i);
  endproperty
  a_cd_pin: assert property (p_cd_pin) else $error("carrier detect status wrong");

  property p_cd_loop;
    reg_rd_i && modem_sel && loopback
      |=> reg_rdata_o[MLF_CD] == $past(modem_output_control_i[MOC_OUT2_BIT]);
  endproperty
  a_cd_loop: assert property (p_cd_loop) else $error("looped carrier status wrong");

  property p_loop;
    loopback ##1 loopback |-> rx_serial_o == $past(tx_serial_i);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path broken");

  c_overrun: cover property (rx_push_i && fifo.full);
  c_err_read: cover property (line_read && fifo.any_err);
  c_resume_wr: cover property (reg_wr_i && resume2_sel);

endmodule

// ---- sim/host_model.sv ----
// Host model that reaches the status registers over the register port.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic       clk_i,
  // Register port, driven on falling edges.
  output logic      [2:0] addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  // -----------------------------------------------------------------
  // Idle port; the caller sets the select inputs before access
  // -----------------------------------------------------------------
  initial begin
    addr_o  = 3'h0;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One write strobe, then the data bus shows a changed pattern once released.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ---- sim/uart_line_modem_status_tb.sv ----
// Self-checking bench for the UART line and modem status block.
`timescale 1ns/1ps
module uart_line_modem_status_tb;
  import uart_status_pkg::*;
  // -----------------------------------------------------------------
  // Stimulus and observation
  // -----------------------------------------------------------------
  logic       ref_clk_i, rst_i, sw_reset_i;
  logic [2:0] reg_addr;
  logic       reg_rd, reg_wr;
  logic [7:0] reg_wdata, reg_rdata, lfc, moc, sfs, rx_char, resume_char, d;
  logic       rx_push, rx_brk, rx_frm, rx_par;
  logic       hold_load, to_shift, hold_last, shift_busy;
  logic       tx_serial, rx_pin, rx_serial, cd_n;
  int         n_errors = 0;
  int         checks_done = 0;

  uart_line_modem_status uart_line_modem_status_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_reset_i(sw_reset_i),
    .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .line_format_control_i(lfc), .modem_output_control_i(moc),
    .special_function_select_i(sfs), .rx_push_i(rx_push), .rx_char_i(rx_char),
    .rx_break_i(rx_brk), .rx_frame_err_i(rx_frm), .rx_parity_err_i(rx_par),
    .tx_hold_load_i(hold_load), .tx_to_shift_i(to_shift), .tx_hold_last_i(hold_last),
    .tx_shift_busy_i(shift_busy), .tx_serial_i(tx_serial), .rx_pin_i(rx_pin),
    .rx_serial_o(rx_serial), .carrier_detect_n_i(cd_n), .second_resume_char_o(resume_char));

  host_model host_model_inst (
    .clk_i(ref_clk_i), .addr_o(reg_addr), .rd_o(reg_rd), .wr_o(reg_wr),
    .wdata_o(reg_wdata), .rdata_i(reg_rdata));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    host_model_inst.rd(a, d);
    chk(what, exp, d);
  endtask

  // The receiver strobe is one cycle wide, with its flags beside it.
  task automatic push(input logic [7:0] c, input logic b, input logic f, input logic p);
    @(negedge ref_clk_i);
    {rx_push, rx_char, rx_brk, rx_frm, rx_par} = {1'b1, c, b, f, p};
    @(negedge ref_clk_i);
    {rx_push, rx_brk, rx_frm, rx_par} = {1'b0, ~b, ~f, ~p};
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(OFS_LINE_STAT, LINE_STAT_RESET, "line status at reset");
    rd_chk(OFS_MODEM, MODEM_RESET, "modem status at reset");
    chk("resume char at reset", RESUME2_RESET, resume_char);
    $display("test reset done");
  endtask

  // An errored byte ahead of a clean one: flags follow the head byte.
  task automatic t_errors;
    for (int k = 0; k < 3; k++) begin
      push(8'(8'h40 + k), k == 0, k == 1, k == 2);
      push(8'h55, 1'b0, 1'b0, 1'b0);
      rd_chk(OFS_LINE_STAT, 8'he1 | (8'h10 >> k), "error head");
      rd_chk(OFS_RX_DATA, 8'(8'h40 + k), "errored char");
      rd_chk(OFS_LINE_STAT, 8'h61, "clean head");
      rd_chk(OFS_RX_DATA, 8'h55, "clean char");
    end
    rd_chk(OFS_LINE_STAT, 8'h60, "empty after errors");
    $display("test errors done");
  endtask

  // One byte more than the FIFO holds; that byte must be lost.
  task automatic t_overrun;
    for (int i = 0; i < RXF_DEPTH + 1; i++) push(8'(i), 1'b0, 1'b0, 1'b0);
    rd_chk(OFS_LINE_STAT, 8'h63, "overrun set");
    rd_chk(OFS_LINE_STAT, 8'h61, "overrun cleared");
    for (int i = 0; i < RXF_DEPTH; i++) rd_chk(OFS_RX_DATA, 8'(i), "fifo order");
    rd_chk(OFS_LINE_STAT, 8'h60, "fifo drained");
    $display("test overrun done");
  endtask

  task automatic t_transmit;
    @(negedge ref_clk_i);
    {hold_load, shift_busy} = 2'b10;
    @(negedge ref_clk_i);
    hold_load = 1'b0;
    rd_chk(OFS_LINE_STAT, 8'h00, "holding loaded");
    @(negedge ref_clk_i);
    {to_shift, hold_last, shift_busy} = 3'b111;
    @(negedge ref_clk_i);
    {to_shift, hold_last} = 2'b00;
    rd_chk(OFS_LINE_STAT, 8'h20, "shift busy");
    @(negedge ref_clk_i);
    shift_busy = 1'b0;
    rd_chk(OFS_LINE_STAT, 8'h60, "transmitter idle");
    $display("test transmit done");
  endtask

  // The resume character is hidden while its select bit is set, and survives soft reset.
  task automatic t_resume;
    @(negedge ref_clk_i);
    {lfc, sfs} = {ENH_ACCESS_KEY, 8'h00};
    host_model_inst.wr(OFS_RESUME2, 8'ha5);
    rd_chk(OFS_RESUME2, 8'ha5, "resume char");
    chk("resume char out", 8'ha5, resume_char);
    @(negedge ref_clk_i);
    sfs = 8'h04;
    host_model_inst.wr(OFS_RESUME2, 8'h3c);
    rd_chk(OFS_RESUME2, 8'h00, "hidden resume char");
    @(negedge ref_clk_i);
    sfs = 8'h00;
    @(negedge ref_clk_i);
    sw_reset_i = 1'b1;
    @(negedge ref_clk_i);
    sw_reset_i = 1'b0;
    rd_chk(OFS_RESUME2, 8'ha5, "resume after soft reset");
    @(negedge ref_clk_i);
    lfc = 8'h00;
    host_model_inst.wr(OFS_LINE_STAT, 8'h1f);
    rd_chk(OFS_LINE_STAT, 8'h60, "line status write");
    host_model_inst.wr(OFS_MODEM, 8'hff);
    rd_chk(OFS_MODEM, 8'h00, "modem status write");
    // Only a power-on reset may bring the resume character back to its default.
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("resume after power-on", RESUME2_RESET, resume_char);
    $display("test resume done");
  endtask

  task automatic t_modem;
    @(negedge ref_clk_i);
    cd_n = 1'b0;
    rd_chk(OFS_MODEM, 8'h80, "carrier pin low");
    @(negedge ref_clk_i);
    moc = 8'h04;
    rd_chk(OFS_MODEM, 8'h00, "modem deselected");
    @(negedge ref_clk_i);
    moc = 8'h10;
    rd_chk(OFS_MODEM, 8'h00, "loopback out2 low");
    @(negedge ref_clk_i);
    {moc, cd_n, tx_serial, rx_pin} = {8'h18, 1'b1, 1'b0, 1'b1};
    rd_chk(OFS_MODEM, 8'h80, "loopback out2 high");
    chk("looped serial", 8'h00, {7'h00, rx_serial});
    @(negedge ref_clk_i);
    // Transmit line opposite to the pin, so a stuck loopback path shows.
    {moc, rx_pin, tx_serial} = {8'h00, 1'b0, 1'b1};
    @(negedge ref_clk_i);
    chk("pin serial", 8'h00, {7'h00, rx_serial});
    rd_chk(OFS_MODEM, 8'h00, "carrier pin high");
    $display("test modem done");
  endtask

  // -----------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    {rst_i, sw_reset_i, lfc, moc, sfs, rx_char} = {2'b10, 32'h0};
    {rx_push, rx_brk, rx_frm, rx_par, hold_load, to_shift, hold_last} = 7'h0;
    {shift_busy, tx_serial, rx_pin, cd_n} = 4'h7;
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_errors();
    t_overrun();
    t_transmit();
    t_resume();
    t_modem();
    close_out();
  end

  // The tests need about 460 cycles; stop well beyond that.
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule
